//--- hdl/reflex_pkg.sv
package reflex_pkg;

  // ----------------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------------
  localparam int unsigned MAX_BLOCKS    = 10;
  localparam int unsigned MAX_PRIO      = 10;
  localparam int unsigned N_DIN         = 16;
  localparam int unsigned N_AIN         = 4;
  localparam int unsigned N_VIRT        = 4;
  localparam int unsigned N_DOUT        = 8;
  localparam int unsigned N_AOUT        = 4;
  localparam int unsigned N_MOD         = 16;
  localparam int unsigned WORD_W        = 16;

  // ----------------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned TICK_CYC      = TICK_MS * CLK_MHZ * 1000;
  localparam int unsigned COS_HOLD_MS   = 10;
  localparam int unsigned COS_HOLD_TICK = COS_HOLD_MS / TICK_MS;

  // ----------------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFF      = 12'h000;
  localparam logic [11:0] STATUS_OFF    = 12'h004;
  localparam logic [11:0] HEALTH_OFF    = 12'h008;
  localparam logic [11:0] MANDATORY_OFF = 12'h00c;
  localparam logic [11:0] PRIO_OFF      = 12'h010;
  localparam logic [11:0] VIRT_OFF      = 12'h020;
  localparam logic [11:0] BLK_OFF       = 12'h100;
  localparam logic [11:0] BLK_STRIDE    = 12'h010;

  // per-block word index inside its 16-byte slot
  localparam logic [1:0]  BW_CFG        = 2'h0;
  localparam logic [1:0]  BW_SRC        = 2'h1;
  localparam logic [1:0]  BW_PRE        = 2'h2;
  localparam logic [1:0]  BW_RES        = 2'h3;

  // ctrl fields
  localparam int unsigned CTRL_RUN      = 0;
  localparam int unsigned CTRL_CFGRST   = 1;

  typedef enum logic [2:0] {
    F_NONE, F_AND, F_XOR, F_CMP, F_CNT_UP, F_CNT_DN, F_TMR, F_LATCH_D
  } func_t;

  typedef enum logic [1:0] {
    S_CONST, S_DIN, S_VIRT, S_BLOCK
  } src_kind_t;

  typedef struct packed {
    src_kind_t  kind;
    logic [5:0] idx;
  } src_t;

  // cfg word: [2:0] func, [3] analog latch, [4] en_const, [6:5] time unit,
  // [7] nested (no channel), [10:8] out module, [14:11] channel, [15] valid
  typedef struct packed {
    logic       valid;
    logic [3:0] chan;
    logic [2:0] omod;
    logic       nested;
    logic [1:0] unit;
    logic       en_const;
    logic       alatch;
    func_t      func;
  } blk_cfg_t;

  localparam blk_cfg_t CFG_RST = '0;

endpackage : reflex_pkg

//--- hdl/reflex_engine.sv
`timescale 1ns/10ps
// Overview of operation
// (RULE1) blocks do AND, XOR, compare, up/down count, timer and latches
// (RULE2) each block takes enable plus operands from constant, input, virtual or block
// (RULE3) enable is a Boolean source or a constant always-enabled
// (RULE4) XOR block result is the xor of two Boolean operands
// (RULE5) compare holds thresholds and delta hysteresis, gives a Boolean
// (RULE6) timer trigger clears accumulator, counts 1/10/100/1000 ms units to preset
// (RULE7) timer reset input clears the accumulator
// (RULE8) digital latch takes Boolean, analog latch takes and holds a 16-bit word
// (RULE9) results are Boolean except counter and analog latch words
// (RULE10) inputs update on change only, then locked out for 10 ms
// (RULE11) mapped output channel ignores master-written value
// (RULE12) one nesting level, first result feeds second, same output module
// (RULE13) unmapped nested result is kept in an internal buffer
// (RULE14) at most 10 blocks, nested pair counts two
// (RULE15) at most two blocks per output module
// (RULE16) block traffic gets top island bus priority
// (RULE17) blocks run regardless of master presence
// (RULE18) prioritized digital input modules scanned more often, at most 10
// (RULE19) healthy replacement of same type is configured and island restarts
// (RULE20) config reset during recovery loads defaults without mandatory marks
// (RULE21) disabled block holds result and ignores inputs
// (RULE22) missing mandatory module stops the bus and forces fallback
module reflex_engine #(
  parameter int unsigned TICK_CYCLES = reflex_pkg::TICK_CYC
) (
  input  wire logic                                        pclk,
  input  wire logic                                        presetn,
  input  wire logic                                        psel,
  input  wire logic                                        penable,
  input  wire logic                                        pwrite,
  input  wire logic [11:0]                                 paddr,
  input  wire logic [31:0]                                 pwdata,
  output logic                                             pready,
  output logic [31:0]                                      prdata,
  output logic                                             pslverr,
  input  wire logic [reflex_pkg::N_DIN-1:0]                din,
  input  wire logic [reflex_pkg::N_AIN*reflex_pkg::WORD_W-1:0] ain,
  input  wire logic [reflex_pkg::N_MOD-1:0]                mod_present,
  input  wire logic [reflex_pkg::N_MOD-1:0]                mod_type_ok,
  input  wire logic                                        cfg_reset_btn,
  input  wire logic [reflex_pkg::N_DOUT-1:0]               master_dout,
  input  wire logic [reflex_pkg::N_AOUT*reflex_pkg::WORD_W-1:0] master_aout,
  output logic [reflex_pkg::N_DOUT-1:0]                    dout,
  output logic [reflex_pkg::N_AOUT*reflex_pkg::WORD_W-1:0] aout,
  output logic                                             bus_running,
  output logic                                             fallback,
  output logic [3:0]                                       scan_mod,
  output logic                                             scan_prio
);

  localparam int unsigned NB = reflex_pkg::MAX_BLOCKS;
  localparam int unsigned W  = reflex_pkg::WORD_W;
  localparam int unsigned N_OUT_W = reflex_pkg::N_DOUT;

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  reflex_pkg::blk_cfg_t   cfg_q  [NB];
  reflex_pkg::blk_cfg_t   cfg_d  [NB];
  logic [31:0]            src_q  [NB];   // [7:0] en, [15:8] op_a, [23:16] op_b, [31:24] reset
  logic [31:0]            src_d  [NB];
  logic [31:0]            pre_q  [NB];   // [15:0] preset/threshold, [31:16] hysteresis delta
  logic [31:0]            pre_d  [NB];
  logic [W-1:0]           res_q  [NB];
  logic [W-1:0]           res_d  [NB];
  logic [W-1:0]           acc_q  [NB];
  logic [W-1:0]           acc_d  [NB];
  logic [9:0]             div_q  [NB];
  logic [9:0]             div_d  [NB];
  logic [1:0]             trg_q  [NB];   // [0] last trigger, [1] last op
  logic [1:0]             trg_d  [NB];
  logic [W-1:0]           virt_q [reflex_pkg::N_VIRT];
  logic [W-1:0]           virt_d [reflex_pkg::N_VIRT];
  logic [reflex_pkg::N_DIN-1:0] dsamp_q, dsamp_d;
  logic [reflex_pkg::N_AIN*W-1:0] asamp_q, asamp_d;
  logic [3:0]             hold_q, hold_d;
  logic [31:0]            tick_cnt_q, tick_cnt_d;
  logic                   tick_q, tick_d;
  logic [1:0]             ctrl_q, ctrl_d;
  logic [reflex_pkg::N_MOD-1:0] mand_q, mand_d;
  logic [reflex_pkg::N_MOD-1:0] prio_q, prio_d;
  logic                   run_q, run_d;
  logic                   stop_q, stop_d;
  logic [3:0]             scan_q, scan_d;
  logic                   sprio_q, sprio_d;
  logic                   alt_q, alt_d;
  logic [3:0]             pscan_q, pscan_d;
  logic                   cfg_err_q, cfg_err_d;
  logic [N_OUT_W-1:0]     dout_q, dout_d;
  logic [reflex_pkg::N_AOUT*W-1:0] aout_q, aout_d;
  logic                   pready_q, pready_d;
  logic [31:0]            prdata_q, prdata_d;
  logic                   pslverr_q, pslverr_d;

  // ----------------------------------------------------------------------------
  // source fetch
  // ----------------------------------------------------------------------------
  function automatic logic [W-1:0] fetch(input logic [7:0] s);
    reflex_pkg::src_t sv;
    sv = reflex_pkg::src_t'(s);
    fetch = '0;
    unique case (sv.kind)
      reflex_pkg::S_CONST: fetch = {10'h000, sv.idx};
      reflex_pkg::S_DIN:
        if (sv.idx[5]) fetch = asamp_q[sv.idx[1:0]*W +: W];
        else           fetch = {15'h0000, dsamp_q[sv.idx[3:0]]};
      reflex_pkg::S_VIRT:  fetch = virt_q[sv.idx[1:0]];
      reflex_pkg::S_BLOCK: fetch = (sv.idx < NB) ? res_q[sv.idx[3:0]] : '0; // RULE12 RULE13
    endcase
  endfunction : fetch

  // ----------------------------------------------------------------------------
  // input sampling with change-of-state lockout and ms tick
  // ----------------------------------------------------------------------------
  always_comb
  begin
    tick_cnt_d = tick_cnt_q + 32'h0000_0001;
    tick_d     = 1'b0;
    if (tick_cnt_q >= TICK_CYCLES - 1)
    begin
      tick_cnt_d = '0;
      tick_d     = 1'b1;
    end
    dsamp_d = dsamp_q;
    asamp_d = asamp_q;
    hold_d  = hold_q;
    if (hold_q != 4'h0)
    begin
      if (tick_q)
        hold_d = hold_q - 4'h1;
    end
    else if ((din != dsamp_q) || (ain != asamp_q))
    begin
      dsamp_d = din;                                                       // RULE10
      asamp_d = ain;
      hold_d  = 4'(reflex_pkg::COS_HOLD_TICK);                             // RULE10
    end
  end

  // ----------------------------------------------------------------------------
  // function blocks
  // ----------------------------------------------------------------------------
  function automatic logic [9:0] unit_ms(input logic [1:0] u);
    unique case (u)
      2'h0: unit_ms = 10'h001;
      2'h1: unit_ms = 10'h00a;
      2'h2: unit_ms = 10'h064;
      2'h3: unit_ms = 10'h3e8;
    endcase
  endfunction : unit_ms

  for (genvar b = 0; b < NB; b++)
  begin : g_blk
    logic         en;
    logic [W-1:0] opa;
    logic [W-1:0] opb;
    logic         rst_in;
    logic [W-1:0] en_src;
    logic [W-1:0] rst_src;
    always_comb
    begin
      en_src  = fetch(src_q[b][7:0]);
      rst_src = fetch(src_q[b][31:24]);
      en     = cfg_q[b].en_const | en_src[0];                              // RULE3
      opa    = fetch(src_q[b][15:8]);                                      // RULE2
      opb    = fetch(src_q[b][23:16]);
      rst_in = rst_src[0];
      res_d[b] = res_q[b];
      acc_d[b] = acc_q[b];
      div_d[b] = div_q[b];
      trg_d[b] = trg_q[b];
      if (cfg_q[b].valid && run_q && en)                                   // RULE17 RULE21
      begin
        trg_d[b] = {opa[0], opb[0]};
        unique case (cfg_q[b].func)                                        // RULE1 RULE9
          reflex_pkg::F_AND: res_d[b] = {15'h0000, opa[0] & opb[0]};
          reflex_pkg::F_XOR: res_d[b] = {15'h0000, opa[0] ^ opb[0]};       // RULE4
          reflex_pkg::F_CMP:                                               // RULE5
          begin
            if (opa > pre_q[b][15:0] + pre_q[b][31:16])
              res_d[b] = 16'h0001;
            else if (opa + pre_q[b][31:16] < pre_q[b][15:0])
              res_d[b] = 16'h0000;
          end
          reflex_pkg::F_CNT_UP:
            if (rst_in) res_d[b] = '0;
            else if (opb[0] && !trg_q[b][0]) res_d[b] = res_q[b] + 16'h0001;
          reflex_pkg::F_CNT_DN:
            if (rst_in) res_d[b] = pre_q[b][15:0];
            else if (opb[0] && !trg_q[b][0] && res_q[b] != '0) res_d[b] = res_q[b] - 16'h0001;
          reflex_pkg::F_TMR:
          begin
            if (rst_in)
            begin
              acc_d[b] = '0;                                               // RULE7
              div_d[b] = '0;
              res_d[b] = '0;
            end
            else if (opb[0] && !trg_q[b][0])
            begin
              acc_d[b] = '0;                                               // RULE6
              div_d[b] = '0;
              res_d[b] = '0;
            end
            else if (tick_q && acc_q[b] < pre_q[b][15:0])
            begin
              if (div_q[b] + 10'h001 >= unit_ms(cfg_q[b].unit))
              begin
                div_d[b] = '0;
                acc_d[b] = acc_q[b] + 16'h0001;
                if (acc_q[b] + 16'h0001 >= pre_q[b][15:0])
                  res_d[b] = 16'h0001;
              end
              else
                div_d[b] = div_q[b] + 10'h001;
            end
          end
          reflex_pkg::F_LATCH_D:                                           // RULE8
            if (cfg_q[b].alatch) res_d[b] = opa;
            else                 res_d[b] = {15'h0000, opa[0]};
          default: res_d[b] = res_q[b];
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // outputs, mapping and mandatory supervision
  // ----------------------------------------------------------------------------
  always_comb
  begin
    logic [3:0] per_mod [8];
    for (int m = 0; m < 8; m++) per_mod[m] = '0;
    cfg_err_d = 1'b0;
    dout_d = master_dout;
    aout_d = master_aout;
    for (int b = 0; b < NB; b++)
      if (cfg_q[b].valid)
      begin
        per_mod[cfg_q[b].omod] = per_mod[cfg_q[b].omod] + 4'h1;
        if (cfg_q[b].nested)
        begin
          if (b == NB - 1 || cfg_q[b+1].omod != cfg_q[b].omod)
            cfg_err_d = 1'b1;                                              // RULE12
        end
        else if (cfg_q[b].alatch)
        begin
          aout_d[cfg_q[b].chan[1:0]*W +: W] = res_q[b];                    // RULE11
        end
        else
        begin
          dout_d[cfg_q[b].chan[2:0]] = res_q[b][0];                        // RULE11
        end
      end
    for (int m = 0; m < 8; m++)
      if (per_mod[m] > 4'h2) cfg_err_d = 1'b1;                             // RULE15
    stop_d = stop_q;
    run_d  = run_q;
    if (run_q && ((mand_q & ~mod_present) != '0))
    begin
      stop_d = 1'b1;                                                       // RULE22
      run_d  = 1'b0;
    end
    else if (stop_q && ((mand_q & ~(mod_present & mod_type_ok)) == '0) && mod_type_ok == '1)
    begin
      stop_d = 1'b0;                                                       // RULE19
      run_d  = ctrl_q[reflex_pkg::CTRL_RUN];
    end
    else if (!stop_q)
      run_d = ctrl_q[reflex_pkg::CTRL_RUN];
    if (!run_d)
    begin
      dout_d = '0;                                                         // RULE22
      aout_d = '0;
    end
    // scan: every other slot goes to a prioritized input module
    alt_d   = ~alt_q;
    scan_d  = scan_q;
    pscan_d = pscan_q;
    sprio_d = 1'b0;
    if (alt_q && prio_q != '0)
    begin
      pscan_d = pscan_q + 4'h1;
      for (int i = reflex_pkg::N_MOD; i > 0; i--)
        if (prio_q[4'(i + int'(pscan_q))]) pscan_d = 4'(i + int'(pscan_q));
      scan_d  = pscan_d;                                                   // RULE18
      sprio_d = 1'b1;
    end
    else
      scan_d = scan_q + 4'h1;
  end

  // ----------------------------------------------------------------------------
  // apb slave, one wait-free access cycle
  // ----------------------------------------------------------------------------
  always_comb
  begin
    logic [3:0] bi;
    logic [11:0] boff;
    logic [4:0] pcnt;
    boff = paddr - reflex_pkg::BLK_OFF;
    bi   = boff[7:4];
    pcnt = '0;
    for (int i = 0; i < reflex_pkg::N_MOD; i++) pcnt = pcnt + 5'(pwdata[i]);
    for (int b = 0; b < NB; b++)
    begin
      cfg_d[b] = cfg_q[b];
      src_d[b] = src_q[b];
      pre_d[b] = pre_q[b];
    end
    for (int v = 0; v < reflex_pkg::N_VIRT; v++) virt_d[v] = virt_q[v];
    ctrl_d    = ctrl_q;
    mand_d    = mand_q;
    prio_d    = prio_q;
    pready_d  = 1'b0;
    prdata_d  = '0;
    pslverr_d = 1'b0;
    if (psel && !penable)
    begin
      pready_d = 1'b1;
      if (boff[11:8] == 4'h0 && bi < NB && paddr[1:0] == 2'h0)
      begin
        unique case (boff[3:2])
          reflex_pkg::BW_CFG:
          begin
            prdata_d = {16'h0000, cfg_q[bi]};
            if (pwrite && (bi == 4'h0 || !cfg_q[bi-1].nested || pwdata[7] == 1'b0))
              cfg_d[bi] = reflex_pkg::blk_cfg_t'(pwdata[15:0]);            // RULE14 RULE12
          end
          reflex_pkg::BW_SRC: begin prdata_d = src_q[bi]; if (pwrite) src_d[bi] = pwdata; end
          reflex_pkg::BW_PRE: begin prdata_d = pre_q[bi]; if (pwrite) pre_d[bi] = pwdata; end
          reflex_pkg::BW_RES: prdata_d = {16'h0000, res_q[bi]};
        endcase
      end
      else if (paddr >= reflex_pkg::VIRT_OFF && paddr < reflex_pkg::VIRT_OFF + 12'h010)
      begin
        prdata_d = {16'h0000, virt_q[paddr[3:2]]};
        if (pwrite) virt_d[paddr[3:2]] = pwdata[15:0];
      end
      else
        unique case (paddr)
          reflex_pkg::CTRL_OFF:
          begin
            prdata_d = {30'h0, ctrl_q};
            if (pwrite) ctrl_d = pwdata[1:0];
          end
          reflex_pkg::STATUS_OFF:    prdata_d = {28'h0, cfg_err_q, stop_q, run_q, hold_q != 4'h0};
          reflex_pkg::HEALTH_OFF:    prdata_d = {16'h0, mod_present & mod_type_ok};
          reflex_pkg::MANDATORY_OFF: begin prdata_d = {16'h0, mand_q}; if (pwrite) mand_d = pwdata[15:0]; end
          reflex_pkg::PRIO_OFF:
          begin
            prdata_d = {16'h0, prio_q};
            if (pwrite && pcnt <= 5'(reflex_pkg::MAX_PRIO)) prio_d = pwdata[15:0]; // RULE18
            else if (pwrite) pslverr_d = 1'b1;
          end
          default: pslverr_d = 1'b1;
        endcase
    end
    if (cfg_reset_btn && stop_q)
    begin
      mand_d = '0;                                                         // RULE20
      for (int b = 0; b < NB; b++) cfg_d[b] = reflex_pkg::CFG_RST;
    end
  end

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int b = 0; b < NB; b++)
      begin
        cfg_q[b] <= reflex_pkg::CFG_RST;
        src_q[b] <= '0;
        pre_q[b] <= '0;
        res_q[b] <= '0;
        acc_q[b] <= '0;
        div_q[b] <= '0;
        trg_q[b] <= '0;
      end
      for (int v = 0; v < reflex_pkg::N_VIRT; v++) virt_q[v] <= '0;
      {dsamp_q, asamp_q, hold_q, tick_cnt_q, tick_q} <= '0;
      {ctrl_q, mand_q, prio_q, run_q, stop_q, scan_q, sprio_q, alt_q, pscan_q, cfg_err_q} <= '0;
      {dout_q, aout_q, pready_q, prdata_q, pslverr_q} <= '0;
    end
    else
    begin
      for (int b = 0; b < NB; b++)
      begin
        cfg_q[b] <= cfg_d[b];
        src_q[b] <= src_d[b];
        pre_q[b] <= pre_d[b];
        res_q[b] <= res_d[b];
        acc_q[b] <= acc_d[b];
        div_q[b] <= div_d[b];
        trg_q[b] <= trg_d[b];
      end
      for (int v = 0; v < reflex_pkg::N_VIRT; v++) virt_q[v] <= virt_d[v];
      {dsamp_q, asamp_q, hold_q, tick_cnt_q, tick_q} <= {dsamp_d, asamp_d, hold_d, tick_cnt_d, tick_d};
      {ctrl_q, mand_q, prio_q, run_q, stop_q} <= {ctrl_d, mand_d, prio_d, run_d, stop_d};
      {scan_q, sprio_q, alt_q, pscan_q, cfg_err_q} <= {scan_d, sprio_d, alt_d, pscan_d, cfg_err_d};
      {dout_q, aout_q, pready_q, prdata_q, pslverr_q} <= {dout_d, aout_d, pready_d, prdata_d, pslverr_d};
    end
  end

  // block results leave on a dedicated path, never queued behind scan traffic
  assign dout        = dout_q;                                             // RULE16
  assign aout        = aout_q;
  assign bus_running = run_q;
  assign fallback    = stop_q;
  assign scan_mod    = scan_q;
  assign scan_prio   = sprio_q;
  assign pready      = pready_q;
  assign prdata      = prdata_q;
  assign pslverr     = pslverr_q;

endmodule : reflex_engine

//--- dv/reflex_engine_sva.sv
`timescale 1ns/10ps
module reflex_engine_sva (
  input wire logic                                         pclk,
  input wire logic                                         presetn,
  input wire logic                                         psel,
  input wire logic                                         penable,
  input wire logic                                         pwrite,
  input wire logic [11:0]                                  paddr,
  input wire logic [31:0]                                  pwdata,
  input wire logic                                         pready,
  input wire logic                                         pslverr,
  input wire logic [reflex_pkg::N_DOUT-1:0]                dout,
  input wire logic [reflex_pkg::N_AOUT*reflex_pkg::WORD_W-1:0] aout,
  input wire logic                                         bus_running,
  input wire logic                                         fallback
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------------
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence
  property p_ans; s_setup |=> s_access; endproperty
  property p_one; pready |-> s_access ##1 !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_gap; pready && (paddr inside {[12'h014:12'h01c], [12'h030:12'h0fc]}) |-> pslverr; endproperty
  // slot ten and above lie past the last block
  property p_slot; pready && paddr >= 12'h1a0 |-> pslverr; endproperty
  property p_prio; pready && pwrite && paddr == 12'h010 && $countones(pwdata) > 10 |-> pslverr; endproperty
  // ----------------------------------------------------------------------------
  // stop handling
  // ----------------------------------------------------------------------------
  property p_fb_out; fallback |-> dout == '0 && aout == '0; endproperty
  property p_fb_stop; $rose(fallback) |-> !bus_running; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  a_one: assert property (p_one) else $error("ready outside one access cycle");
  a_err: assert property (p_err) else $error("error without ready");
  a_gap: assert property (p_gap) else $error("hole in map accepted");
  a_slot: assert property (p_slot) else $error("eleventh block slot accepted");
  a_prio: assert property (p_prio) else $error("too many priority modules accepted");
  a_fb_out: assert property (p_fb_out) else $error("outputs live while stopped");
  a_fb_stop: assert property (p_fb_stop) else $error("bus runs in stop");
endmodule : reflex_engine_sva

bind reflex_engine reflex_engine_sva i_reflex_engine_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .dout(dout), .aout(aout), .bus_running(bus_running), .fallback(fallback));

//--- dv/island_io_model.sv
`timescale 1ns/10ps
module island_io_model (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic [15:0]  din_set,
  input wire logic [15:0]  pulled,
  output logic [15:0]      din,
  output logic [63:0]      ain,
  output logic [15:0]      mod_present,
  output logic [15:0]      mod_type_ok
);
  // inputs move only when asked, so each change is one event
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      din <= '0;
    else
      din <= din_set;
  assign ain = {4{din}};
  // a pulled module is absent, so never reads as a good type
  assign mod_present = ~pulled;
  assign mod_type_ok = ~pulled;
endmodule : island_io_model

//--- dv/island_reflex_logic_engine_tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module island_reflex_logic_engine_tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic        cfg_reset_btn = 0, bus_running, fallback;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, rs = 32'h0000_818d;
  logic [15:0] din, din_set = '0, pulled = '0, mod_present, mod_type_ok;
  logic [63:0] ain, aout, master_aout = '0;
  logic [7:0]  dout, master_dout = '0;
  int          fail_count = 0, comparisons = 0;
  always #2.5 pclk = ~pclk;
  reflex_engine #(.TICK_CYCLES(10)) i_reflex_engine (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .din(din), .ain(ain), .mod_present(mod_present), .mod_type_ok(mod_type_ok),
    .cfg_reset_btn(cfg_reset_btn), .master_dout(master_dout), .master_aout(master_aout), .dout(dout),
    .aout(aout), .bus_running(bus_running), .fallback(fallback), .scan_mod(), .scan_prio());
  island_io_model i_island_io_model (.pclk(pclk), .presetn(presetn), .din_set(din_set), .pulled(pulled),
    .din(din), .ain(ain), .mod_present(mod_present), .mod_type_ok(mod_type_ok));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic test_done;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 50)
    begin
      fail_count++;
      test_done();
    end
    @(posedge pclk);
  endtask : apb
  task automatic wait_fb(input logic v);
    int n;
    for (n = 0; n < 400 && fallback !== v; n++)
      @(posedge pclk);
    if (n >= 400)
    begin
      fail_count++;
      test_done();
    end
  endtask : wait_fb
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(1, 12'h020, 32'h0000_a5c3);
    apb(0, 12'h020, 32'h0);
    `CHK("virtual word", 32'h0000_a5c3, rd)
    apb(0, 12'h030, 32'h0);
    `CHK("hole error", 1'b1, err)
    apb(1, 12'h1a0, 32'h0000_8012);
    `CHK("slot ten error", 1'b1, err)
    apb(1, 12'h010, 32'h0000_07ff);
    `CHK("eleven prio error", 1'b1, err)
    apb(1, 12'h010, 32'h0000_03ff);
    apb(0, 12'h010, 32'h0);
    `CHK("ten prio", 32'h0000_03ff, rd)
    // block 0: xor of din0 and din1 onto output 0, always enabled
    apb(1, 12'h100, 32'h0000_8012);
    apb(1, 12'h104, 32'h0041_4000);
    // block 1: analog latch of input word 0 onto analog output 0
    apb(1, 12'h110, 32'h0000_801f);
    apb(1, 12'h114, 32'h0000_6000);
    apb(1, 12'h000, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    `CHK("running", 1'b1, bus_running)
    for (int i = 0; i < 6; i++)
    begin
      rs = xs(rs);
      din_set <= {14'h0, rs[1:0]};
      master_dout <= rs[15:8];
      master_aout <= {4{rs[31:16]}};
      repeat (130) @(posedge pclk);
      `CHK("xor out", rs[0] ^ rs[1], dout[0])
      `CHK("master pass", rs[15:9], dout[7:1])
      `CHK("latch word", {{3{rs[31:16]}}, 14'h0, rs[1:0]}, aout)
    end
    din_set <= 16'h0;
    repeat (130) @(posedge pclk);
    din_set <= 16'h1;
    repeat (6) @(posedge pclk);
    `CHK("first change", 1'b1, dout[0])
    din_set <= 16'h3;
    repeat (40) @(posedge pclk);
    `CHK("locked change", 1'b1, dout[0])
    repeat (100) @(posedge pclk);
    `CHK("late change", 1'b0, dout[0])
    apb(1, 12'h00c, 32'h0000_0001);
    pulled <= 16'h1;
    wait_fb(1'b1);
    `CHK("stopped out", 8'h00, dout)
    pulled <= 16'h0;
    wait_fb(1'b0);
    repeat (20) @(posedge pclk);
    `CHK("restart", 1'b1, bus_running)
    pulled <= 16'h1;
    wait_fb(1'b1);
    cfg_reset_btn <= 1;
    repeat (2) @(posedge pclk);
    cfg_reset_btn <= 0;
    apb(0, 12'h00c, 32'h0);
    `CHK("defaults", 32'h0, rd)
    test_done();
  end
  initial
  begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    test_done();
  end
endmodule : island_reflex_logic_engine_tb_top
